// ===== core/omcs_pkg.sv
// Shared constants, types and states of the optical module control block
package omcs_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned SYS_HZ = 20_000_000;
    localparam int unsigned SYS_KHZ = SYS_HZ / 1000;
    // Least laser-off hold to reset a latched fault
    localparam int unsigned T_RESET_US = 10;
    localparam int unsigned T_RESET_CYC = (T_RESET_US * SYS_KHZ + 999) / 1000;
    // Longest power-on to data-ready time
    localparam int unsigned T_DATA_MS = 1000;
    localparam int unsigned T_DATA_CYC = T_DATA_MS * SYS_KHZ;
    // Power-on to serial bus ready; no figure known, plain default
    localparam int unsigned T_SERIAL_MS = 1;
    localparam int unsigned T_SERIAL_CYC = T_SERIAL_MS * SYS_KHZ;

    // ----------------------------------------------------------------
    // Serial addresses and register map
    // ----------------------------------------------------------------
    localparam logic [6:0] DEV_ID_A0 = 7'h50;
    localparam logic [6:0] DEV_ID_A2 = 7'h51;
    localparam logic [7:0] REG_CTRL = 8'h6e;
    localparam logic [7:0] REG_EXT = 8'h76;
    localparam int unsigned CTRL_HW_OFF_BIT = 7;
    localparam int unsigned CTRL_SOFT_OFF_BIT = 6;
    localparam int unsigned CTRL_RS1_PIN_BIT = 5;
    localparam int unsigned CTRL_RS0_PIN_BIT = 4;
    localparam int unsigned CTRL_SOFT_RS0_BIT = 3;
    localparam int unsigned CTRL_FAULT_BIT = 2;
    localparam int unsigned CTRL_LOST_BIT = 1;
    localparam int unsigned CTRL_READY_BIT = 0;
    localparam int unsigned EXT_SOFT_RS1_BIT = 3;
    localparam logic SOFT_OFF_RST = 1'b0;
    localparam logic SOFT_RS_RST = 1'b0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic laser_en;
        logic rx_cdr;
        logic tx_cdr;
    } omcs_ctl_t;

    typedef struct packed {
        logic fault;
        logic lost;
    } omcs_sts_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_PTR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } omcs_st_t;

endpackage

// ===== core/omcs_top.sv
// Control and status logic of a pluggable optical transceiver module
//
// Overview of operation
// R01 - Laser-off rising disables optical output
// R02 - Laser-off falling restores output within 1 ms
// R03 - Init after laser-off fall clears fault
// R04 - Fault pin asserts within 100 us
// R05 - Host holds laser-off 10 us to reset
// R06 - Signal-lost pin asserts within 100 us
// R07 - Signal-lost pin clears within 100 us
// R08 - Signal-lost detector has assert/deassert hysteresis
// R09 - Speed pins engage or bypass clock recovery
// R10 - Soft laser-off bit disables output
// R11 - Clearing soft laser-off restores output
// R12 - Soft fault status bit follows fault
// R13 - Soft signal-lost bit follows detector
// R14 - Soft speed bits steer clock recovery
// R15 - Data-ready bit set within 1000 ms
// R16 - Serial bus serves after ready interval
// R17 - Host leaves 20 us bus idle
// R18 - Byte writes complete within 10 ms
// R19 - Host clocks bus at 100 kHz max
// R20 - Fault latched until laser-off reset pulse
// R21 - Hardware and soft laser-off are ORed
`timescale 1ns/1ps
module omcs_top import omcs_pkg::*; #(
    parameter int unsigned DATA_CYC = T_DATA_CYC,
    parameter int unsigned SERIAL_CYC = T_SERIAL_CYC
) (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Link clock
    input wire logic clk_link,
    // Host control pins
    input wire logic laser_off_pin,
    input wire logic speed_choice_first,
    input wire logic speed_choice_second,
    // Management bus, open drain data
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Host status pins
    output logic laser_fault,
    output logic receive_signal_lost,
    // Optics side, link domain
    input wire logic laser_fault_cond,
    input wire logic pwr_above_assert,
    input wire logic pwr_above_deassert,
    output logic laser_enable,
    output logic rx_cdr_engage,
    output logic tx_cdr_engage
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] rd_byte(
        input logic a2,
        input logic [7:0] ptr,
        input logic [7:0] ctrl,
        input logic [7:0] ext
    );
        logic [7:0] b;
        b = 8'h00;
        if (a2 && ptr == REG_CTRL) begin
            b = ctrl;
        end else if (a2 && ptr == REG_EXT) begin
            b = ext;
        end
        return b;
    endfunction

    function automatic logic fill8(input logic [3:0] c);
        return c == 4'h8;
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] pin_m_q;
    logic [4:0] pin_s_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_m_q <= 5'h03;
            pin_s_q <= 5'h03;
        end else begin
            pin_m_q <= {laser_off_pin, speed_choice_first, speed_choice_second, scl_i, sda_i};
            pin_s_q <= pin_m_q;
        end
    end

    logic hw_off;
    logic rs0_pin;
    logic rs1_pin;
    logic scl_s;
    logic sda_s;
    assign {hw_off, rs0_pin, rs1_pin, scl_s, sda_s} = pin_s_q;

    // ----------------------------------------------------------------
    // Power-on readiness
    // ----------------------------------------------------------------
    logic [31:0] up_cnt_q;
    logic data_ready_q;
    logic serial_ready_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            up_cnt_q <= 32'h0;
            data_ready_q <= 1'b0;
            serial_ready_q <= 1'b0;
        end else begin
            if (up_cnt_q < DATA_CYC) begin
                up_cnt_q <= up_cnt_q + 32'h1;
            end
            // R15 data ready flag
            data_ready_q <= up_cnt_q >= DATA_CYC;
            // R16 bus opens late
            serial_ready_q <= up_cnt_q >= SERIAL_CYC;
        end
    end

    // ----------------------------------------------------------------
    // Status from link domain
    // ----------------------------------------------------------------
    omcs_sts_t sts_lq;
    omcs_sts_t sts_m_q;
    omcs_sts_t sts_s_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sts_m_q <= '{fault: 1'b0, lost: 1'b1};
            sts_s_q <= '{fault: 1'b0, lost: 1'b1};
        end else begin
            sts_m_q <= sts_lq;
            sts_s_q <= sts_m_q;
        end
    end

    // ----------------------------------------------------------------
    // Fault latch and status pins
    // ----------------------------------------------------------------
    logic [31:0] off_cnt_q;
    logic hw_off_p_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            off_cnt_q <= 32'h0;
            hw_off_p_q <= 1'b0;
        end else begin
            hw_off_p_q <= hw_off;
            if (!hw_off) begin
                off_cnt_q <= 32'h0;
            end else if (off_cnt_q < T_RESET_CYC) begin
                off_cnt_q <= off_cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            laser_fault <= 1'b0;
        end else if (sts_s_q.fault) begin
            // R04 fault pin, set wins
            laser_fault <= 1'b1;
        end else if (hw_off_p_q && !hw_off && off_cnt_q >= T_RESET_CYC) begin
            // R20 cleared by long pulse
            // R03 init clears fault
            laser_fault <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            receive_signal_lost <= 1'b1;
        end else begin
            // R06 R07 pin follows detector
            receive_signal_lost <= sts_s_q.lost;
        end
    end

    // ----------------------------------------------------------------
    // Management bus slave
    // ----------------------------------------------------------------
    // R19 oversampled well above bus rate
    logic scl_p_q;
    logic sda_p_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise = scl_s && !scl_p_q;
    assign scl_fall = !scl_s && scl_p_q;
    assign bus_start = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign bus_stop = scl_s && scl_p_q && !sda_p_q && sda_s;

    logic soft_off_q;
    logic soft_rs0_q;
    logic soft_rs1_q;
    logic [7:0] ctrl_rd;
    logic [7:0] ext_rd;
    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[CTRL_HW_OFF_BIT] = hw_off;
        ctrl_rd[CTRL_SOFT_OFF_BIT] = soft_off_q;
        ctrl_rd[CTRL_RS1_PIN_BIT] = rs1_pin;
        ctrl_rd[CTRL_RS0_PIN_BIT] = rs0_pin;
        ctrl_rd[CTRL_SOFT_RS0_BIT] = soft_rs0_q;
        // R12 soft fault bit
        ctrl_rd[CTRL_FAULT_BIT] = laser_fault;
        // R13 soft lost bit
        ctrl_rd[CTRL_LOST_BIT] = receive_signal_lost;
        ctrl_rd[CTRL_READY_BIT] = data_ready_q;
        ext_rd = 8'h00;
        ext_rd[EXT_SOFT_RS1_BIT] = soft_rs1_q;
    end

    omcs_st_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] ptr_q;
    logic rw_q;
    logic a2_q;
    logic mack_q;
    logic wr_en;
    logic [7:0] nxt;
    assign wr_en = scl_fall && st_q == ST_WDATA && fill8(cnt_q) && a2_q;
    assign nxt = rd_byte(a2_q, ptr_q, ctrl_rd, ext_rd);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            a2_q <= 1'b0;
            mack_q <= 1'b0;
            sda_oe <= 1'b0;
        end else if (bus_stop) begin
            st_q <= ST_IDLE;
            sda_oe <= 1'b0;
        end else if (bus_start) begin
            st_q <= ST_ADDR;
            cnt_q <= 4'h0;
            sda_oe <= 1'b0;
        end else if (scl_rise) begin
            if (st_q == ST_RDATA_ACK) begin
                mack_q <= !sda_s;
            end else if (st_q == ST_ADDR || st_q == ST_PTR || st_q == ST_WDATA) begin
                sh_q <= {sh_q[6:0], sda_s};
                cnt_q <= cnt_q + 4'h1;
            end else if (st_q == ST_RDATA) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end else if (scl_fall) begin
            unique case (st_q)
                ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                ST_ADDR: begin
                    if (fill8(cnt_q)) begin
                        cnt_q <= 4'h0;
                        // R16 no answer before ready
                        if (serial_ready_q && (sh_q[7:1] == DEV_ID_A0 || sh_q[7:1] == DEV_ID_A2)) begin
                            st_q <= ST_ADDR_ACK;
                            a2_q <= sh_q[7:1] == DEV_ID_A2;
                            rw_q <= sh_q[0];
                            sda_oe <= 1'b1;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (rw_q) begin
                        st_q <= ST_RDATA;
                        sh_q <= nxt;
                        sda_oe <= !nxt[7];
                    end else begin
                        st_q <= ST_PTR;
                        sda_oe <= 1'b0;
                    end
                end
                ST_PTR: begin
                    if (fill8(cnt_q)) begin
                        cnt_q <= 4'h0;
                        ptr_q <= sh_q;
                        st_q <= ST_PTR_ACK;
                        sda_oe <= 1'b1;
                    end
                end
                ST_PTR_ACK, ST_WDATA_ACK: begin
                    st_q <= ST_WDATA;
                    sda_oe <= 1'b0;
                end
                ST_WDATA: begin
                    if (fill8(cnt_q)) begin
                        cnt_q <= 4'h0;
                        ptr_q <= ptr_q + 8'h1;
                        st_q <= ST_WDATA_ACK;
                        sda_oe <= 1'b1;
                    end
                end
                ST_RDATA: begin
                    if (fill8(cnt_q)) begin
                        cnt_q <= 4'h0;
                        ptr_q <= ptr_q + 8'h1;
                        st_q <= ST_RDATA_ACK;
                        sda_oe <= 1'b0;
                    end else begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        sda_oe <= !sh_q[6];
                    end
                end
                ST_RDATA_ACK: begin
                    if (mack_q) begin
                        st_q <= ST_RDATA;
                        sh_q <= nxt;
                        sda_oe <= !nxt[7];
                    end else begin
                        st_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Open drain: the pin is only ever pulled low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Soft control bits
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            soft_off_q <= SOFT_OFF_RST;
            soft_rs0_q <= SOFT_RS_RST;
            soft_rs1_q <= SOFT_RS_RST;
        end else if (wr_en) begin
            // R18 write lands at byte end
            if (ptr_q == REG_CTRL) begin
                soft_off_q <= sh_q[CTRL_SOFT_OFF_BIT];
                soft_rs0_q <= sh_q[CTRL_SOFT_RS0_BIT];
            end
            if (ptr_q == REG_EXT) begin
                soft_rs1_q <= sh_q[EXT_SOFT_RS1_BIT];
            end
        end
    end

    omcs_ctl_t ctl_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= '{laser_en: 1'b0, rx_cdr: 1'b0, tx_cdr: 1'b0};
        end else begin
            // R21 either source disables
            // R01 R02 R10 R11 laser gate
            ctl_q.laser_en <= !(hw_off || soft_off_q || laser_fault);
            // R09 R14 speed selection
            ctl_q.rx_cdr <= rs0_pin || soft_rs0_q;
            ctl_q.tx_cdr <= rs1_pin || soft_rs1_q;
        end
    end

    // ----------------------------------------------------------------
    // Link domain
    // ----------------------------------------------------------------
    omcs_ctl_t ctl_m_q;
    omcs_ctl_t ctl_s_q;
    logic [2:0] ana_m_q;
    logic [2:0] ana_s_q;
    always_ff @(posedge clk_link or negedge rst_n) begin
        if (!rst_n) begin
            ctl_m_q <= '{laser_en: 1'b0, rx_cdr: 1'b0, tx_cdr: 1'b0};
            ctl_s_q <= '{laser_en: 1'b0, rx_cdr: 1'b0, tx_cdr: 1'b0};
            ana_m_q <= 3'h0;
            ana_s_q <= 3'h0;
        end else begin
            // Independent levels, so per-bit sync is safe
            ctl_m_q <= ctl_q;
            ctl_s_q <= ctl_m_q;
            ana_m_q <= {laser_fault_cond, pwr_above_assert, pwr_above_deassert};
            ana_s_q <= ana_m_q;
        end
    end

    assign laser_enable = ctl_s_q.laser_en;
    assign rx_cdr_engage = ctl_s_q.rx_cdr;
    assign tx_cdr_engage = ctl_s_q.tx_cdr;

    always_ff @(posedge clk_link or negedge rst_n) begin
        if (!rst_n) begin
            sts_lq <= '{fault: 1'b0, lost: 1'b1};
        end else begin
            sts_lq.fault <= ana_s_q[2];
            // R08 hysteresis between two levels
            if (!ana_s_q[1]) begin
                sts_lq.lost <= 1'b1;
            end else if (ana_s_q[0]) begin
                sts_lq.lost <= 1'b0;
            end
        end
    end

endmodule

// ===== dv/omcs_properties.sv
// Port-level assertions of the optical module control block
`timescale 1ns/1ps
module omcs_properties import omcs_pkg::*; #(
    parameter int unsigned DATA_CYC = T_DATA_CYC,
    parameter int unsigned SERIAL_CYC = T_SERIAL_CYC
) (
    // Clocks and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_link,
    // Host side
    input wire logic laser_off_pin,
    input wire logic speed_choice_first,
    input wire logic speed_choice_second,
    input wire logic scl_i,
    input wire logic sda_oe,
    input wire logic laser_fault,
    input wire logic receive_signal_lost,
    // Optics side
    input wire logic laser_fault_cond,
    input wire logic pwr_above_assert,
    input wire logic pwr_above_deassert,
    input wire logic laser_enable,
    input wire logic rx_cdr_engage,
    input wire logic tx_cdr_engage
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Saturates at the bus ready point
    logic [31:0] up_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 32'h0;
        end else if (up_q < SERIAL_CYC) begin
            up_q <= up_q + 32'h1;
        end
    end
    // Eight cycles outlast the synchroniser stages
    sequence mid_band_s;
        (pwr_above_assert && !pwr_above_deassert)[*8];
    endsequence
    sequence fault_held_s;
        laser_fault[*8];
    endsequence
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    bus_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        up_q < SERIAL_CYC |-> !sda_oe) else $error("bus answered before ready");
    ack_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(sda_oe) |-> !scl_i) else $error("data line pulled while clock high");
    fault_rise_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(laser_fault_cond) |-> ##[1:40] laser_fault) else $error("fault pin late");
    fault_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        laser_fault && laser_off_pin |=> laser_fault) else $error("fault dropped early");
    lost_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(pwr_above_assert) |-> ##[1:40] receive_signal_lost) else $error("lost late");
    lost_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(pwr_above_deassert) |-> ##[1:40] !receive_signal_lost)
        else $error("lost clear late");
    lost_band_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mid_band_s |-> $stable(receive_signal_lost)) else $error("lost moved in band");
    laser_off_a: assert property (@(posedge clk_link) disable iff (!rst_n)
        $rose(laser_off_pin) |-> ##[1:24] !laser_enable) else $error("laser still on");
    fault_off_a: assert property (@(posedge clk_link) disable iff (!rst_n)
        fault_held_s |-> !laser_enable) else $error("laser on during fault");
    rx_engage_a: assert property (@(posedge clk_link) disable iff (!rst_n)
        $rose(speed_choice_first) |-> ##[1:24] rx_cdr_engage) else $error("rx not engaged");
    tx_engage_a: assert property (@(posedge clk_link) disable iff (!rst_n)
        $rose(speed_choice_second) |-> ##[1:24] tx_cdr_engage) else $error("tx not engaged");
endmodule

// ===== dv/omcs_host_model.sv
// Host controller model, master of the management bus
`timescale 1ns/1ps
module omcs_host_model (
    // Clock
    input wire logic clk_sys,
    // Bus
    input wire logic sda_line,
    output logic scl_q,
    output logic sda_q
);
    // quarter bit of 50 cycles, SCL at 100 kHz
    localparam int Q = 50;
    initial begin
        scl_q = 1'b1;
        sda_q = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // One clock pulse, line sampled mid high phase
    task automatic bit_c(input logic v, output logic s);
        sda_q <= v;
        wt(Q);
        scl_q <= 1'b1;
        wt(Q);
        s = sda_line;
        wt(Q);
        scl_q <= 1'b0;
        wt(Q);
    endtask
    task automatic start_c();
        sda_q <= 1'b1;
        wt(Q);
        scl_q <= 1'b1;
        wt(2 * Q);
        sda_q <= 1'b0;
        wt(2 * Q);
        scl_q <= 1'b0;
        wt(Q);
    endtask
    task automatic stop_c();
        sda_q <= 1'b0;
        wt(Q);
        scl_q <= 1'b1;
        wt(2 * Q);
        sda_q <= 1'b1;
        // idle of 20 us before next start
        wt(400);
    endtask
    task automatic byte_c(input logic [7:0] b, output logic nk);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(b[i], s);
        end
        bit_c(1'b1, nk);
    endtask
    task automatic addr_only(input logic [6:0] dev, output logic nk);
        start_c();
        byte_c({dev, 1'b0}, nk);
        stop_c();
    endtask
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] dat,
                             output logic nk);
        logic n0, n1, n2;
        start_c();
        byte_c({dev, 1'b0}, n0);
        byte_c(ptr, n1);
        byte_c(dat, n2);
        stop_c();
        nk = n0 | n1 | n2;
    endtask
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d,
                            output logic nk);
        logic n0, n1, n2, s;
        start_c();
        byte_c({dev, 1'b0}, n0);
        byte_c(ptr, n1);
        start_c();
        byte_c({dev, 1'b1}, n2);
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'b1, d[i]);
        end
        // Master refuses the next byte, read ends
        bit_c(1'b1, s);
        stop_c();
        nk = n0 | n1 | n2;
    endtask
endmodule

// ===== dv/optical_module_control_status_test.sv
// Self-checking testbench of the optical module control block
`timescale 1ns/1ps
module optical_module_control_status_test import omcs_pkg::*;;
    localparam int unsigned SER = 3000;
    localparam int unsigned DAT = 20000;
    typedef struct packed {
        logic [5:0] in;
        logic [2:0] out;
    } omcs_row_t;
    // Pins off rs0 rs1, soft off rs0 rs1 -> enable rx tx
    omcs_row_t rows [4] = '{'{6'h00, 3'h4}, '{6'h31, 3'h3}, '{6'h0e, 3'h3}, '{6'h01, 3'h5}};
    logic clk_sys = 1'b0;
    logic clk_link = 1'b0;
    logic rst_n = 1'b0;
    logic laser_off_pin = 1'b0;
    logic speed_choice_first = 1'b0;
    logic speed_choice_second = 1'b0;
    logic laser_fault_cond = 1'b0;
    logic pwr_above_assert = 1'b0;
    logic pwr_above_deassert = 1'b0;
    logic scl, sda, sda_host, sda_o, sda_oe;
    logic laser_fault, receive_signal_lost, laser_enable, rx_cdr_engage, tx_cdr_engage;
    logic nk, n0;
    logic [7:0] rd;
    int cyc = 0;
    int fail_count = 0;
    int samples_checked = 0;

    always #25 clk_sys = ~clk_sys;
    always #16 clk_link = ~clk_link;
    // Pull-up on the data wire
    assign sda = sda_host & (sda_oe ? sda_o : 1'b1);

    omcs_top #(.DATA_CYC(DAT), .SERIAL_CYC(SER)) omcs_top_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link),
        .laser_off_pin(laser_off_pin), .speed_choice_first(speed_choice_first),
        .speed_choice_second(speed_choice_second), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .laser_fault(laser_fault),
        .receive_signal_lost(receive_signal_lost), .laser_fault_cond(laser_fault_cond),
        .pwr_above_assert(pwr_above_assert), .pwr_above_deassert(pwr_above_deassert),
        .laser_enable(laser_enable), .rx_cdr_engage(rx_cdr_engage),
        .tx_cdr_engage(tx_cdr_engage));
    omcs_host_model omcs_host_model_i (
        .clk_sys(clk_sys), .sda_line(sda), .scl_q(scl), .sda_q(sda_host));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle();
        repeat (40) @(posedge clk_sys);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Ceiling above the expected run of about 86800 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 99000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        check({receive_signal_lost, laser_fault, laser_enable, sda_oe}, 4'h8);
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        omcs_host_model_i.addr_only(DEV_ID_A2, nk);
        check(nk, 1'b1);
        repeat (SER) @(posedge clk_sys);
        omcs_host_model_i.read_reg(DEV_ID_A2, REG_CTRL, rd, nk);
        check({nk, rd}, 9'h002);
        pwr_above_assert <= 1'b1;
        settle();
        check(receive_signal_lost, 1'b1);
        pwr_above_deassert <= 1'b1;
        settle();
        check(receive_signal_lost, 1'b0);
        // Read-only bits of REG_CTRL are always written as ones
        foreach (rows[i]) begin
            {laser_off_pin, speed_choice_first, speed_choice_second} <= rows[i].in[5:3];
            omcs_host_model_i.write_reg(DEV_ID_A2, REG_CTRL,
                {1'b1, rows[i].in[2], 2'h3, rows[i].in[1], 3'h7}, n0);
            omcs_host_model_i.write_reg(DEV_ID_A2, REG_EXT, {4'h0, rows[i].in[0], 3'h0}, nk);
            settle();
            check({n0, nk, laser_enable, rx_cdr_engage, tx_cdr_engage}, rows[i].out);
        end
        {pwr_above_assert, pwr_above_deassert} <= 2'h0;
        settle();
        check(receive_signal_lost, 1'b1);
        laser_fault_cond <= 1'b1;
        settle();
        check({laser_fault, laser_enable}, 2'h2);
        laser_fault_cond <= 1'b0;
        settle();
        check({laser_fault, laser_enable}, 2'h2);
        omcs_host_model_i.read_reg(DEV_ID_A2, REG_CTRL, rd, nk);
        check({nk, rd}, 9'h007);
        laser_off_pin <= 1'b1;
        repeat (100) @(posedge clk_sys);
        laser_off_pin <= 1'b0;
        settle();
        check(laser_fault, 1'b1);
        laser_off_pin <= 1'b1;
        repeat (250) @(posedge clk_sys);
        laser_off_pin <= 1'b0;
        settle();
        check({laser_fault, laser_enable}, 2'h1);
        omcs_host_model_i.read_reg(DEV_ID_A2, REG_EXT, rd, nk);
        check({nk, rd}, 9'h008);
        omcs_host_model_i.addr_only(7'h52, nk);
        check(nk, 1'b1);
        // Mid-run reset drops soft speed bits and closes the bus again
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check({receive_signal_lost, laser_enable, rx_cdr_engage, tx_cdr_engage}, 4'h8);
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        omcs_host_model_i.addr_only(DEV_ID_A2, nk);
        check(nk, 1'b1);
        end_of_test();
    end
endmodule

bind omcs_top omcs_properties #(.DATA_CYC(DATA_CYC), .SERIAL_CYC(SERIAL_CYC)) omcs_properties_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link), .laser_off_pin(laser_off_pin),
    .speed_choice_first(speed_choice_first), .speed_choice_second(speed_choice_second),
    .scl_i(scl_i), .sda_oe(sda_oe), .laser_fault(laser_fault),
    .receive_signal_lost(receive_signal_lost), .laser_fault_cond(laser_fault_cond),
    .pwr_above_assert(pwr_above_assert), .pwr_above_deassert(pwr_above_deassert),
    .laser_enable(laser_enable), .rx_cdr_engage(rx_cdr_engage),
    .tx_cdr_engage(tx_cdr_engage));
